// *** sgcr_pkg.sv ***
// constants for the global switch control register bank
`default_nettype none
package sgcr_pkg;
  // -----------------------------------------------------------------
  // register offsets
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_FAMILY = 8'h00;
  localparam logic [7:0] ADDR_IDRUN = 8'h01;
  localparam logic [7:0] ADDR_GC0 = 8'h02;
  localparam logic [7:0] ADDR_GC1 = 8'h03;
  localparam logic [7:0] ADDR_GC2 = 8'h04;
  // -----------------------------------------------------------------
  // identity values (arbitrary, neutral)
  // -----------------------------------------------------------------
  localparam logic [7:0] FAMILY_CODE = 8'h5a;
  localparam logic [3:0] CHIP_CODE = 4'h6;
  localparam logic [2:0] REV_CODE = 3'h0;
  // -----------------------------------------------------------------
  // reset values and writable masks
  // -----------------------------------------------------------------
  localparam logic RUN_RST = 1'b1;
  localparam logic [7:0] GC0_RST = 8'h00;
  localparam logic [7:0] GC0_MASK = 8'hb8;
  localparam logic [7:0] GC1_RST = 8'h34;
  localparam logic [7:0] GC2_RST = 8'hf0;
  localparam logic [7:0] ZERO8 = 8'h00;
  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int RUN_BIT = 0;
  localparam int GC0_NEW_BACKOFF = 7;
  localparam int GC0_FLUSH_DYN = 5;
  localparam int GC0_FLUSH_STAT = 4;
  localparam int GC0_PASS_FC = 3;
  localparam int GC1_PASS_ALL = 7;
  localparam int GC1_TAIL_TAG = 6;
  localparam int GC1_TX_FC = 5;
  localparam int GC1_RX_FC = 4;
  localparam int GC1_LEN_CHECK = 3;
  localparam int GC1_AGE_EN = 2;
  localparam int GC1_FAST_AGE = 1;
  localparam int GC1_AGGR_BO = 0;
  localparam int GC2_VLAN_STRICT = 7;
  localparam int GC2_MC_STORM_OFF = 6;
  localparam int GC2_CS_BP = 5;
  localparam int GC2_FAIR = 4;
  localparam int GC2_NO_EXC_DROP = 3;
  localparam int GC2_HUGE = 2;
  localparam int GC2_LEGAL_MAX = 1;
  // -----------------------------------------------------------------
  // frame limits
  // -----------------------------------------------------------------
  localparam logic [10:0] LEN_HUGE = 11'h77c;
  localparam logic [10:0] LEN_DEFAULT = 11'h600;
  localparam logic [10:0] LEN_TAGGED = 11'h5f2;
  localparam logic [10:0] LEN_UNTAGGED = 11'h5ee;
  localparam logic [15:0] LEN_TYPE_LIMIT = 16'h05dc;
  localparam logic [4:0] EXC_COLLISIONS = 5'h10;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int FAST_AGE_US = 800;
  localparam int FAST_AGE_CYC = (FAST_AGE_US * 1000) / CLK_PERIOD_NS;
  localparam int SLOW_AGE_CYC = 25000000;
endpackage
`default_nettype wire

// *** sgcr_age_if.sv ***
// carrier between the register bank and its aging timer
`timescale 1ns/10ps
`default_nettype none
interface sgcr_age_if;
  logic enable;
  logic fast;
  logic [31:0] fast_limit;
  logic [31:0] slow_limit;
  logic tick;
  modport ctrl (output enable, output fast, output fast_limit,
    output slow_limit, input tick);
  modport timer (input enable, input fast, input fast_limit,
    input slow_limit, output tick);
endinterface
`default_nettype wire

// *** sgcr_age_timer.sv ***
// aging tick divider with fast and slow periods
`timescale 1ns/10ps
`default_nettype none
module sgcr_age_timer (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  sgcr_age_if.timer age
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic fast_reg;
  logic tick_reg;
  wire logic [31:0] limit = age.fast ? age.fast_limit : age.slow_limit;
  wire logic at_end = (cnt_reg >= limit - 32'h00000001);
  wire logic restart = !age.enable || (age.fast != fast_reg);
  assign cnt_next = (restart || at_end) ? 32'h00000000
    : cnt_reg + 32'h00000001;
  assign age.tick = tick_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 32'h00000000;
      fast_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      fast_reg <= age.fast;
      tick_reg <= !restart && at_end;
    end
  end
endmodule
`default_nettype wire

// *** sgcr_global_regs.sv ***
// global identification and control register bank of the switch
//
// What this block does
// RL1 - engine forwards while run bit is one, reset one; cleared stops it
// RL2 - control0 bit 7 selects alternative back-off, else standard
// RL3 - control0 bit 5 flushes dynamically learned table entries
// RL4 - control0 bit 4 flushes static table entries
// RL5 - control0 bit 3 forwards flow-control frames, clear drops them
// RL6 - control1 bit 7 forwards errored frames, only with sniffer mode
// RL7 - control1 bit 6 enables tail tagging on processor port
// RL8 - control1 bit 5 clear stops pause generation, reset one
// RL9 - control1 bit 4 clear ignores received pause, reset one
// RL10 - control1 bit 3 drops frames whose length field mismatches
// RL11 - control1 bit 2 enables aging of learned entries, reset one
// RL12 - control1 bit 1 shortens aging period to 800 us
// RL13 - control1 bit 0 selects aggressive half-duplex back-off
// RL14 - control2 bit 7 keeps all frames inside port-VLAN, reset one
// RL15 - control2 bit 6 limits only broadcast; clear adds group frames
// RL16 - control2 bit 5 selects carrier-sense or collision backpressure
// RL17 - control2 bit 4 selects fair flow-control mode, default on
// RL18 - control2 bit 3 clear drops frames at 16 or more collisions
// RL19 - control2 bit 2 accepts up to 1916 bytes, overriding bit 1
// RL20 - bit 1 clear allows 1536; set limits 1522 tagged, 1518 untagged
// RL21 - identification shows chip code bits 7-4, revision bits 3-1
// RL22 - writes to read-only bits and control0 reserved bits are ignored; control2 bit 0 takes writes
// RL23 - eight-bit registers; globals at addresses 0x00 to 0x0F
`timescale 1ns/10ps
`default_nettype none
module sgcr_global_regs #(
  parameter int FAST_AGE_CYCLES = sgcr_pkg::FAST_AGE_CYC,
  parameter int SLOW_AGE_CYCLES = sgcr_pkg::SLOW_AGE_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // engine controls
  output logic SWITCH_RUN,
  output logic ALT_BACKOFF,
  output logic FLUSH_DYNAMIC,
  output logic FLUSH_STATIC,
  output logic TAIL_TAG_EN,
  output logic TX_PAUSE_EN,
  output logic AGGR_BACKOFF,
  output logic VLAN_STRICT,
  output logic CS_BACKPRESSURE,
  output logic FAIR_MODE,
  output logic AGE_TICK,
  // frame to judge
  input wire logic FRAME_VALID,
  input wire logic [10:0] FRAME_LEN,
  input wire logic FRAME_TAGGED,
  input wire logic [15:0] FRAME_LEN_TYPE,
  input wire logic [10:0] FRAME_PAYLOAD_LEN,
  input wire logic FRAME_BAD,
  input wire logic FRAME_IS_FLOWCTL,
  input wire logic FRAME_IS_PAUSE,
  input wire logic DA_ALL_ONES,
  input wire logic DA_GROUP,
  input wire logic SNIFF_MODE,
  // frame decision
  output logic DEC_VALID,
  output logic DEC_FORWARD,
  output logic DEC_STORM,
  output logic PAUSE_ACT,
  // collision judgement
  input wire logic COLL_EVENT,
  input wire logic [4:0] COLL_COUNT,
  output logic COLL_DROP
);
  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic run_reg;
  logic [7:0] gc0_reg;
  logic [7:0] gc1_reg;
  logic [7:0] gc2_reg;
  logic [7:0] rdata_reg;
  logic dvalid_reg;
  logic dfwd_reg;
  logic dstorm_reg;
  logic pause_reg;
  logic coll_reg;

  // -----------------------------------------------------------------
  // address decode
  // -----------------------------------------------------------------
  wire logic sel_idrun = (REG_ADDR == sgcr_pkg::ADDR_IDRUN);
  wire logic sel_gc0 = (REG_ADDR == sgcr_pkg::ADDR_GC0);
  wire logic sel_gc1 = (REG_ADDR == sgcr_pkg::ADDR_GC1);
  wire logic sel_gc2 = (REG_ADDR == sgcr_pkg::ADDR_GC2);
  wire logic [7:0] idrun_val = {sgcr_pkg::CHIP_CODE, sgcr_pkg::REV_CODE,
    run_reg}; // see RL21
  // unmapped and out-of-bank offsets read zero; see RL23
  wire logic [7:0] rd_mux =
    (REG_ADDR == sgcr_pkg::ADDR_FAMILY) ? sgcr_pkg::FAMILY_CODE :
    sel_idrun ? idrun_val :
    sel_gc0 ? gc0_reg :
    sel_gc1 ? gc1_reg :
    sel_gc2 ? gc2_reg : sgcr_pkg::ZERO8;
  // read-only and reserved bits masked off; see RL22
  wire logic [7:0] gc0_wr = REG_WDATA & sgcr_pkg::GC0_MASK;

  always_ff @(posedge CLK) begin
    if (RST) begin
      run_reg <= sgcr_pkg::RUN_RST;
      gc0_reg <= sgcr_pkg::GC0_RST;
      gc1_reg <= sgcr_pkg::GC1_RST;
      gc2_reg <= sgcr_pkg::GC2_RST;
      rdata_reg <= sgcr_pkg::ZERO8;
    end else begin
      if (REG_WR && sel_idrun) begin
        run_reg <= REG_WDATA[sgcr_pkg::RUN_BIT]; // see RL1
      end
      if (REG_WR && sel_gc0) begin
        gc0_reg <= gc0_wr; // see RL22
      end
      if (REG_WR && sel_gc1) begin
        gc1_reg <= REG_WDATA;
      end
      if (REG_WR && sel_gc2) begin
        gc2_reg <= REG_WDATA;
      end
      if (REG_RD) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // -----------------------------------------------------------------
  // control outputs
  // -----------------------------------------------------------------
  assign REG_RDATA = rdata_reg;
  assign SWITCH_RUN = run_reg; // see RL1
  assign ALT_BACKOFF = gc0_reg[sgcr_pkg::GC0_NEW_BACKOFF]; // see RL2
  assign FLUSH_DYNAMIC = gc0_reg[sgcr_pkg::GC0_FLUSH_DYN]; // see RL3
  assign FLUSH_STATIC = gc0_reg[sgcr_pkg::GC0_FLUSH_STAT]; // see RL4
  assign TAIL_TAG_EN = gc1_reg[sgcr_pkg::GC1_TAIL_TAG]; // see RL7
  assign TX_PAUSE_EN = gc1_reg[sgcr_pkg::GC1_TX_FC]; // see RL8
  assign AGGR_BACKOFF = gc1_reg[sgcr_pkg::GC1_AGGR_BO]; // see RL13
  assign VLAN_STRICT = gc2_reg[sgcr_pkg::GC2_VLAN_STRICT]; // see RL14
  assign CS_BACKPRESSURE = gc2_reg[sgcr_pkg::GC2_CS_BP]; // see RL16
  assign FAIR_MODE = gc2_reg[sgcr_pkg::GC2_FAIR]; // see RL17

  // -----------------------------------------------------------------
  // aging timer
  // -----------------------------------------------------------------
  sgcr_age_if age_bus ();
  assign age_bus.enable = gc1_reg[sgcr_pkg::GC1_AGE_EN]; // see RL11
  assign age_bus.fast = gc1_reg[sgcr_pkg::GC1_FAST_AGE]; // see RL12
  assign age_bus.fast_limit = FAST_AGE_CYCLES;
  assign age_bus.slow_limit = SLOW_AGE_CYCLES;
  assign AGE_TICK = age_bus.tick;

  sgcr_age_timer u_age (
    .clk (CLK),
    .rst (RST),
    .age (age_bus.timer)
  );

  // -----------------------------------------------------------------
  // frame judgement
  // -----------------------------------------------------------------
  wire logic huge_en = gc2_reg[sgcr_pkg::GC2_HUGE];
  wire logic legal_en = gc2_reg[sgcr_pkg::GC2_LEGAL_MAX];
  wire logic [10:0] legal_lim = FRAME_TAGGED ? sgcr_pkg::LEN_TAGGED
    : sgcr_pkg::LEN_UNTAGGED;
  wire logic [10:0] size_lim = huge_en ? sgcr_pkg::LEN_HUGE // see RL19
    : (legal_en ? legal_lim : sgcr_pkg::LEN_DEFAULT); // see RL20
  wire logic too_long = (FRAME_LEN > size_lim);
  wire logic len_bad = gc1_reg[sgcr_pkg::GC1_LEN_CHECK]
    && (FRAME_LEN_TYPE < sgcr_pkg::LEN_TYPE_LIMIT)
    && (FRAME_LEN_TYPE != {5'h00, FRAME_PAYLOAD_LEN}); // see RL10
  wire logic err_drop = FRAME_BAD
    && !(gc1_reg[sgcr_pkg::GC1_PASS_ALL] && SNIFF_MODE); // see RL6
  wire logic fc_drop = FRAME_IS_FLOWCTL
    && !gc0_reg[sgcr_pkg::GC0_PASS_FC]; // see RL5
  wire logic fwd = run_reg && !too_long && !len_bad && !err_drop
    && !fc_drop; // see RL1
  wire logic storm = DA_ALL_ONES
    || (!gc2_reg[sgcr_pkg::GC2_MC_STORM_OFF] && DA_GROUP); // see RL15
  wire logic pause_hit = FRAME_IS_PAUSE
    && gc1_reg[sgcr_pkg::GC1_RX_FC]; // see RL9
  wire logic coll_hit = COLL_EVENT
    && (COLL_COUNT >= sgcr_pkg::EXC_COLLISIONS)
    && !gc2_reg[sgcr_pkg::GC2_NO_EXC_DROP]; // see RL18

  always_ff @(posedge CLK) begin
    if (RST) begin
      dvalid_reg <= 1'b0;
      dfwd_reg <= 1'b0;
      dstorm_reg <= 1'b0;
      pause_reg <= 1'b0;
      coll_reg <= 1'b0;
    end else begin
      dvalid_reg <= FRAME_VALID;
      dfwd_reg <= FRAME_VALID && fwd;
      dstorm_reg <= FRAME_VALID && storm;
      pause_reg <= FRAME_VALID && pause_hit;
      coll_reg <= coll_hit;
    end
  end

  assign DEC_VALID = dvalid_reg;
  assign DEC_FORWARD = dfwd_reg;
  assign DEC_STORM = dstorm_reg;
  assign PAUSE_ACT = pause_reg;
  assign COLL_DROP = coll_reg;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  logic [31:0] gap_reg;
  logic seen_reg;
  logic fast_on_reg;
  wire logic fast_on = gc1_reg[sgcr_pkg::GC1_AGE_EN]
    && gc1_reg[sgcr_pkg::GC1_FAST_AGE];
  always_ff @(posedge CLK) begin
    if (RST) begin
      gap_reg <= 32'h00000000;
      seen_reg <= 1'b0;
      fast_on_reg <= 1'b0;
    end else begin
      gap_reg <= (AGE_TICK || !fast_on) ? 32'h00000000
        : gap_reg + 32'h00000001;
      fast_on_reg <= fast_on;
      seen_reg <= fast_on && fast_on_reg && (seen_reg || AGE_TICK);
    end
  end

  sequence s_gc1_write;
    REG_WR && sel_gc1;
  endsequence
  sequence s_stop_write;
    REG_WR && sel_idrun && !REG_WDATA[sgcr_pkg::RUN_BIT];
  endsequence

  property p_stop_blocks;
    @(posedge CLK) disable iff (RST)
    s_stop_write ##1 (FRAME_VALID && !(REG_WR && sel_idrun))
      |=> DEC_VALID && !DEC_FORWARD;
  endproperty
  a_stop_blocks: assert property (p_stop_blocks) // see RL1
    else $error("frame forwarded after stop");

  property p_id_read;
    @(posedge CLK) disable iff (RST)
    REG_RD && sel_idrun |=> REG_RDATA[7:1] == {sgcr_pkg::CHIP_CODE,
      sgcr_pkg::REV_CODE};
  endproperty
  a_id_read: assert property (p_id_read) // see RL21
    else $error("identification field wrong");

  property p_gc0_reserved;
    @(posedge CLK) disable iff (RST)
    REG_WR && sel_gc0 |=> (gc0_reg & ~sgcr_pkg::GC0_MASK) == 8'h00;
  endproperty
  a_gc0_reserved: assert property (p_gc0_reserved) // see RL22
    else $error("reserved control bit took a write");

  property p_tx_pause;
    @(posedge CLK) disable iff (RST)
    s_gc1_write |=> TX_PAUSE_EN == $past(REG_WDATA[sgcr_pkg::GC1_TX_FC]);
  endproperty
  a_tx_pause: assert property (p_tx_pause) // see RL8
    else $error("pause generation enable not updated");

  property p_fc_drop;
    @(posedge CLK) disable iff (RST)
    FRAME_VALID && FRAME_IS_FLOWCTL && !gc0_reg[sgcr_pkg::GC0_PASS_FC]
      |=> !DEC_FORWARD;
  endproperty
  a_fc_drop: assert property (p_fc_drop) // see RL5
    else $error("flow-control frame forwarded");

  property p_size;
    @(posedge CLK) disable iff (RST)
    FRAME_VALID && !huge_en && legal_en && !FRAME_TAGGED
      && FRAME_LEN > sgcr_pkg::LEN_UNTAGGED |=> !DEC_FORWARD;
  endproperty
  a_size: assert property (p_size) // see RL20
    else $error("oversize untagged frame forwarded");

  property p_storm;
    @(posedge CLK) disable iff (RST)
    FRAME_VALID && DA_GROUP && !gc2_reg[sgcr_pkg::GC2_MC_STORM_OFF]
      |=> DEC_STORM;
  endproperty
  a_storm: assert property (p_storm) // see RL15
    else $error("group frame not storm limited");

  property p_coll;
    @(posedge CLK) disable iff (RST)
    COLL_EVENT && COLL_COUNT >= sgcr_pkg::EXC_COLLISIONS
      |=> COLL_DROP == !$past(gc2_reg[sgcr_pkg::GC2_NO_EXC_DROP]);
  endproperty
  a_coll: assert property (p_coll) // see RL18
    else $error("excessive collision drop wrong");

  property p_fast_age;
    @(posedge CLK) disable iff (RST)
    AGE_TICK && seen_reg && fast_on
      |-> gap_reg == FAST_AGE_CYCLES - 1;
  endproperty
  a_fast_age: assert property (p_fast_age) // see RL12
    else $error("fast age period wrong");

  sequence s_age_off;
    !gc1_reg[sgcr_pkg::GC1_AGE_EN];
  endsequence

  property p_age_off;
    @(posedge CLK) disable iff (RST)
    s_age_off ##1 s_age_off |-> !AGE_TICK;
  endproperty
  a_age_off: assert property (p_age_off) // see RL11
    else $error("age tick while aging disabled");

  property p_pause_off;
    @(posedge CLK) disable iff (RST)
    FRAME_VALID && FRAME_IS_PAUSE && !gc1_reg[sgcr_pkg::GC1_RX_FC]
      |=> !PAUSE_ACT;
  endproperty
  a_pause_off: assert property (p_pause_off) // see RL9
    else $error("pause honoured while receive flow control off");

  property p_run_write;
    @(posedge CLK) disable iff (RST)
    REG_WR && sel_idrun
      |=> SWITCH_RUN == $past(REG_WDATA[sgcr_pkg::RUN_BIT]);
  endproperty
  a_run_write: assert property (p_run_write) // see RL1
    else $error("run control not updated");

  property p_huge_ok;
    @(posedge CLK) disable iff (RST)
    FRAME_VALID && run_reg && huge_en && FRAME_LEN <= sgcr_pkg::LEN_HUGE
      && !FRAME_BAD && !FRAME_IS_FLOWCTL
      && !gc1_reg[sgcr_pkg::GC1_LEN_CHECK] |=> DEC_FORWARD;
  endproperty
  a_huge_ok: assert property (p_huge_ok) // see RL19
    else $error("huge frame within limit dropped");

  property p_default_max;
    @(posedge CLK) disable iff (RST)
    FRAME_VALID && !huge_en && !legal_en
      && FRAME_LEN > sgcr_pkg::LEN_DEFAULT |=> !DEC_FORWARD;
  endproperty
  a_default_max: assert property (p_default_max) // see RL20
    else $error("frame above default limit forwarded");
endmodule
`default_nettype wire

// *** sgcr_global_regs_tb.sv ***
// self-checking testbench for the global switch control register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ----------------------------------------
  // stimulus signals and case rows
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] gc0;
    logic [7:0] gc1;
    logic [7:0] gc2;
    logic [10:0] len;
    logic tag;
    logic [15:0] lt;
    logic [10:0] pl;
    logic [5:0] flg;
    logic [2:0] res;
  } sgcr_row_t;
  localparam int fast_n = 20;
  localparam int slow_n = 50;
  logic clk, rst, reg_wr, reg_rd, f_valid, f_tag, f_bad, f_fc, f_pause;
  logic f_ones, f_grp, f_sniff, coll_event, seen;
  logic [7:0] reg_addr, reg_wdata, rd_data;
  logic [10:0] f_len, f_pl;
  logic [15:0] f_lt;
  logic [4:0] coll_count;
  wire [7:0] reg_rdata;
  wire [9:0] ctl;
  wire run, alt_bo, fl_dyn, fl_stat, tail, tx_p, aggr, vlan, cs_bp, fair;
  wire age_tick, dec_valid, dec_fwd, dec_storm, pause_act, coll_drop;
  wire [3:0] dec;
  int err_count = 0;
  int total_checks = 0;
  int n;
  sgcr_row_t rows [25];
  logic [7:0] reg_exp [3][6];
  logic [9:0] ctl_exp [3];
  assign ctl = {run, alt_bo, fl_dyn, fl_stat, tail, tx_p, aggr, vlan, cs_bp,
    fair};
  assign dec = {dec_valid, dec_fwd, dec_storm, pause_act};
  sgcr_global_regs #(.FAST_AGE_CYCLES(fast_n), .SLOW_AGE_CYCLES(slow_n))
  u_sgcr_global_regs (.CLK(clk), .RST(rst), .REG_ADDR(reg_addr),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
    .REG_RDATA(reg_rdata), .SWITCH_RUN(run), .ALT_BACKOFF(alt_bo),
    .FLUSH_DYNAMIC(fl_dyn), .FLUSH_STATIC(fl_stat), .TAIL_TAG_EN(tail),
    .TX_PAUSE_EN(tx_p), .AGGR_BACKOFF(aggr), .VLAN_STRICT(vlan),
    .CS_BACKPRESSURE(cs_bp), .FAIR_MODE(fair), .AGE_TICK(age_tick),
    .FRAME_VALID(f_valid), .FRAME_LEN(f_len), .FRAME_TAGGED(f_tag),
    .FRAME_LEN_TYPE(f_lt), .FRAME_PAYLOAD_LEN(f_pl), .FRAME_BAD(f_bad),
    .FRAME_IS_FLOWCTL(f_fc), .FRAME_IS_PAUSE(f_pause), .DA_ALL_ONES(f_ones),
    .DA_GROUP(f_grp), .SNIFF_MODE(f_sniff), .DEC_VALID(dec_valid),
    .DEC_FORWARD(dec_fwd), .DEC_STORM(dec_storm), .PAUSE_ACT(pause_act),
    .COLL_EVENT(coll_event), .COLL_COUNT(coll_count), .COLL_DROP(coll_drop));
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // compare, bus and frame tasks
  // ----------------------------------------
  task chk_reg(input string nm, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task chk_bit(input string nm, input logic e, input logic s);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %b seen %b", nm, e, s);
    end
  endtask
  task chk_ctl(input string nm, input logic [9:0] e, input logic [9:0] s);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task chk_dec(input string nm, input logic [3:0] e, input logic [3:0] s);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %b seen %b", nm, e, s);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge clk);
    reg_wr = 1'h0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge clk);
    reg_rd = 1'h0;
    d = reg_rdata;
  endtask
  task put(input sgcr_row_t r);
    f_len = r.len;
    f_tag = r.tag;
    f_lt = r.lt;
    f_pl = r.pl;
    {f_bad, f_fc, f_pause, f_ones, f_grp, f_sniff} = r.flg;
  endtask
  task send(input sgcr_row_t r, input logic [3:0] e);
    @(negedge clk);
    put(r);
    f_valid = 1'h1;
    @(negedge clk);
    f_valid = 1'h0;
    chk_dec("decision", e, dec);
  endtask
  task coll(input logic [4:0] c, input logic e);
    @(negedge clk);
    coll_event = 1'h1;
    coll_count = c;
    @(negedge clk);
    coll_event = 1'h0;
    chk_bit("coll_drop", e, coll_drop);
  endtask
  task wait_tick(output int cnt);
    cnt = 0;
    do begin
      @(negedge clk);
      cnt++;
    end while (age_tick !== 1'h1 && cnt < 200);
    if (age_tick !== 1'h1) begin
      err_count++;
      $display("unexpected age_tick expected 1 seen %b", age_tick);
      summarize();
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst, reg_wr, reg_rd, f_valid, coll_event} = 5'h10;
    {reg_addr, reg_wdata} = 16'h0000;
    {f_len, f_pl, f_lt} = 38'h0;
    {f_tag, f_bad, f_fc, f_pause, f_ones, f_grp, f_sniff} = 7'h00;
    coll_count = 5'h00;
    rows = '{
      {8'h00,8'h34,8'hf0,11'h600,1'h0,16'h0800,11'h000,6'h00,3'h4},
      {8'h00,8'h34,8'hf0,11'h601,1'h0,16'h0800,11'h000,6'h00,3'h0},
      {8'h00,8'h34,8'hf2,11'h5ee,1'h0,16'h0800,11'h000,6'h00,3'h4},
      {8'h00,8'h34,8'hf2,11'h5ef,1'h0,16'h0800,11'h000,6'h00,3'h0},
      {8'h00,8'h34,8'hf2,11'h5f2,1'h1,16'h0800,11'h000,6'h00,3'h4},
      {8'h00,8'h34,8'hf2,11'h5f3,1'h1,16'h0800,11'h000,6'h00,3'h0},
      {8'h00,8'h34,8'hf6,11'h77c,1'h1,16'h0800,11'h000,6'h00,3'h4},
      {8'h00,8'h34,8'hf6,11'h77d,1'h0,16'h0800,11'h000,6'h00,3'h0},
      {8'h00,8'h3c,8'hf0,11'h040,1'h0,16'h0064,11'h063,6'h00,3'h0},
      {8'h00,8'h3c,8'hf0,11'h040,1'h0,16'h0064,11'h064,6'h00,3'h4},
      {8'h00,8'h34,8'hf0,11'h040,1'h0,16'h0064,11'h063,6'h00,3'h4},
      {8'h00,8'h3c,8'hf0,11'h040,1'h0,16'h05dc,11'h063,6'h00,3'h4},
      {8'h00,8'h34,8'hf0,11'h040,1'h0,16'h0800,11'h000,6'h20,3'h0},
      {8'h00,8'hb4,8'hf0,11'h040,1'h0,16'h0800,11'h000,6'h21,3'h4},
      {8'h00,8'hb4,8'hf0,11'h040,1'h0,16'h0800,11'h000,6'h20,3'h0},
      {8'h00,8'h34,8'hf0,11'h040,1'h0,16'h0800,11'h000,6'h01,3'h4},
      {8'h00,8'h34,8'hf0,11'h040,1'h0,16'h0800,11'h000,6'h10,3'h0},
      {8'h08,8'h34,8'hf0,11'h040,1'h0,16'h0800,11'h000,6'h10,3'h4},
      {8'h00,8'h34,8'hf0,11'h040,1'h0,16'h0800,11'h000,6'h18,3'h1},
      {8'h00,8'h24,8'hf0,11'h040,1'h0,16'h0800,11'h000,6'h18,3'h0},
      {8'h00,8'h34,8'hf0,11'h040,1'h0,16'h0800,11'h000,6'h06,3'h6},
      {8'h00,8'h34,8'hf0,11'h040,1'h0,16'h0800,11'h000,6'h02,3'h4},
      {8'h00,8'h34,8'hb0,11'h040,1'h0,16'h0800,11'h000,6'h02,3'h6},
      {8'h00,8'h34,8'hb0,11'h040,1'h0,16'h0800,11'h000,6'h06,3'h6},
      {8'h00,8'h34,8'hb0,11'h040,1'h0,16'h0800,11'h000,6'h00,3'h4}};
    reg_exp = '{
      '{sgcr_pkg::FAMILY_CODE, {sgcr_pkg::CHIP_CODE, sgcr_pkg::REV_CODE,
        1'h1}, 8'h00, 8'h34, 8'hf0, 8'h00},
      '{sgcr_pkg::FAMILY_CODE, {sgcr_pkg::CHIP_CODE, sgcr_pkg::REV_CODE,
        1'h1}, 8'hb8, 8'hff, 8'hff, 8'h00},
      '{sgcr_pkg::FAMILY_CODE, {sgcr_pkg::CHIP_CODE, sgcr_pkg::REV_CODE,
        1'h0}, 8'h00, 8'h00, 8'h00, 8'h00}};
    ctl_exp = '{10'h217, 10'h3ff, 10'h000};
    repeat (3) @(negedge clk);
    rst = 1'h0;
    chk_reg("reset rdata", 8'h00, reg_rdata);
    for (int p = 0; p < 3; p++) begin
      for (int a = 0; a < 6 && p > 0; a++) begin
        wr(a[7:0], (p == 1) ? 8'hff : 8'h00);
      end
      chk_ctl("controls", ctl_exp[p], ctl);
      for (int a = 0; a < 6; a++) begin
        rd(a[7:0], rd_data);
        chk_reg("register read", reg_exp[p][a], rd_data);
      end
      $display("test register phase %0d done", p);
    end
    rd(8'hff, rd_data);
    chk_reg("unmapped read", 8'h00, rd_data);
    send(rows[24], 4'h8);
    wr(8'h01, 8'h01);
    @(negedge clk);
    reg_addr = 8'h01;
    reg_wdata = 8'h00;
    reg_wr = 1'h1;
    @(negedge clk);
    reg_wr = 1'h0;
    put(rows[24]);
    f_valid = 1'h1;
    @(negedge clk);
    f_valid = 1'h0;
    chk_dec("stopped frame", 4'h8, dec);
    wr(8'h01, 8'h01);
    $display("test stopped engine done");
    foreach (rows[i]) begin
      wr(8'h02, rows[i].gc0);
      wr(8'h03, rows[i].gc1);
      wr(8'h04, rows[i].gc2);
      send(rows[i], 4'h8 | rows[i].res);
    end
    $display("test frame rows done");
    wr(8'h04, 8'hf0);
    @(negedge clk);
    put(rows[1]);
    f_valid = 1'h1;
    @(negedge clk);
    chk_dec("first frame", 4'h8, dec);
    put(rows[0]);
    @(negedge clk);
    f_valid = 1'h0;
    chk_dec("second frame", 4'hc, dec);
    $display("test back to back done");
    coll(5'h10, 1'h1);
    coll(5'h0f, 1'h0);
    coll(5'h1f, 1'h1);
    wr(8'h04, 8'hf8);
    coll(5'h10, 1'h0);
    $display("test collisions done");
    wr(8'h03, 8'h36);
    wait_tick(n);
    wait_tick(n);
    chk_reg("fast age gap", fast_n[7:0], n[7:0]);
    wr(8'h03, 8'h34);
    wait_tick(n);
    wait_tick(n);
    chk_reg("slow age gap", slow_n[7:0], n[7:0]);
    wr(8'h03, 8'h30);
    seen = 1'h0;
    repeat (150) begin
      @(negedge clk);
      if (age_tick !== 1'h0) seen = 1'h1;
    end
    chk_bit("age tick disabled", 1'h0, seen);
    $display("test aging done");
    wr(8'h03, 8'h00);
    @(negedge clk);
    rst = 1'h1;
    @(negedge clk);
    rst = 1'h0;
    chk_ctl("controls after reset", 10'h217, ctl);
    rd(8'h03, rd_data);
    chk_reg("control one after reset", 8'h34, rd_data);
    $display("test second reset done");
    summarize();
  end
endmodule
`default_nettype wire
